// ==== src/esd_detector.sv ====
// Purpose: leaves data mode for command mode on guard + 3 chars + guard
// Assumes: received bytes arrive as one-cycle strobes, settings as ports
// Notes:   out-of-range settings are clamped to their legal bounds
// Behaviour
// - programmable 8-bit escape char, compared per byte
// - escape char resets to plus sign
// - exactly three matching escape bytes needed
// - silence guard interval before and after sequence
// - guard interval in ms, 2..0x6D3, default 1000
// - command mode times out back to data mode
// - timeout in 100 ms units, 2..0x1770, default 100
`timescale 1ns/10ps
module esd_detector
  import esd_pkg::*;
#(
  parameter int unsigned TickLen = TickCycles
)(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // received byte stream
  input  wire logic        rxValid,
  input  wire logic [7:0]  rxByte,
  // setting writes
  input  wire logic        escCharWr,
  input  wire logic [7:0]  escCharIn,
  input  wire logic        guardWr,
  input  wire logic [10:0] guardIn,
  input  wire logic        cmdToWr,
  input  wire logic [12:0] cmdToIn,
  // command interpreter feedback
  input  wire logic        cmdValid,
  input  wire logic        cmdExit,
  // results
  output logic             cmdMode,
  output logic             enterPulse,
  output logic             timeoutPulse,
  output logic             dataValid,
  output logic [7:0]       dataByte,
  output logic [7:0]       escCharSetting,
  output logic [10:0]      guardIntervalSetting,
  output logic [12:0]      commandTimeoutSetting
);

  typedef struct packed {
    esd_state_e  state;
    logic [7:0]  escChar;
    logic [10:0] guard;
    logic [12:0] cmdTo;
    logic [10:0] msCnt;     // ms of silence / elapsed
    logic [6:0]  sub100;    // ms within a 100 ms step
    logic [12:0] toCnt;     // 100 ms steps in command mode
    logic [1:0]  held;      // escape bytes held back
    logic        cmdMode;
    logic        enter;
    logic        tout;
    logic        dValid;
    logic [7:0]  dByte;
    logic        flush;     // aborting byte still to replay
    logic [7:0]  abByte;    // byte that broke the sequence
  } esd_s;

  esd_s st_q;
  esd_s st_d;
  logic msTick;

  // millisecond time base
  esd_tick #(
    .Period (TickLen)
  ) u_tick (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (msTick)
  );

  // clamp a guard write into its legal span
  function automatic logic [10:0] clampGuard(input logic [10:0] v);
    return (v < GuardMin) ? GuardMin : (v > GuardMax) ? GuardMax : v;
  endfunction : clampGuard

  // clamp a timeout write into its legal span
  function automatic logic [12:0] clampTo(input logic [12:0] v);
    return (v < CmdToMin) ? CmdToMin : (v > CmdToMax) ? CmdToMax : v;
  endfunction : clampTo

  // next state of the whole detector
  always_comb
  begin
    st_d        = st_q;
    st_d.enter  = 1'b0;
    st_d.tout   = 1'b0;
    st_d.dValid = 1'b0;
    if (escCharWr)
      st_d.escChar = escCharIn;
    if (guardWr)
      st_d.guard = clampGuard(guardIn);
    if (cmdToWr)
      st_d.cmdTo = clampTo(cmdToIn);
    if (msTick && st_q.msCnt != 11'h07FF)
      st_d.msCnt = st_q.msCnt + 11'h001;
    unique case (st_q.state)
      ESD_DATA:
      begin
        // new byte first, idle cycles replay held escapes, then the breaker
        if (rxValid)
        begin
          st_d.dValid = 1'b1;
          st_d.dByte  = rxByte;
          st_d.msCnt  = 11'h000;
        end
        else if (st_q.held != 2'd0)
        begin
          st_d.dValid = 1'b1;
          st_d.dByte  = st_q.escChar;
          st_d.held   = st_q.held - 2'd1;
        end
        else if (st_q.flush)
        begin
          st_d.dValid = 1'b1;
          st_d.dByte  = st_q.abByte;
          st_d.flush  = 1'b0;
        end
        else if (st_q.msCnt >= st_q.guard)
          st_d.state = ESD_ARMED;
      end
      ESD_ARMED:
      begin
        if (rxValid)
        begin
          st_d.msCnt = 11'h000;
          if (rxByte == st_q.escChar)
          begin
            st_d.held  = 2'd1;
            st_d.state = ESD_COUNT;
          end
          else
          begin
            st_d.dValid = 1'b1;
            st_d.dByte  = rxByte;
            st_d.state  = ESD_DATA;
          end
        end
      end
      ESD_COUNT, ESD_TRAIL:
      begin
        if (rxValid)
        begin
          st_d.msCnt = 11'h000;
          if (rxByte == st_q.escChar && st_q.held < 2'(EscCount))
          begin
            st_d.held = st_q.held + 2'd1;
            if (st_q.held == 2'(EscCount - 1))
              st_d.state = ESD_TRAIL;
          end
          else
          begin
            // abort: held bytes replay, then this byte
            st_d.dValid = 1'b1;
            st_d.dByte  = st_q.escChar;
            st_d.held   = st_q.held - 2'd1;
            st_d.flush  = 1'b1;
            st_d.abByte = rxByte;
            st_d.state  = ESD_DATA;
          end
        end
        else if (st_q.state == ESD_COUNT && st_q.msCnt >= st_q.guard)
          st_d.state = ESD_DATA;                      // too slow
        else if (st_q.state == ESD_TRAIL && st_q.msCnt >= st_q.guard)
        begin
          st_d.state   = ESD_CMD;
          st_d.held    = 2'd0;
          st_d.cmdMode = 1'b1;
          st_d.enter   = 1'b1;
          st_d.sub100  = 7'd0;
          st_d.toCnt   = 13'h0000;
        end
      end
      ESD_CMD:
      begin
        if (msTick)
        begin
          if (st_q.sub100 == 7'(CmdUnitMs - 1))
          begin
            st_d.sub100 = 7'd0;
            st_d.toCnt  = st_q.toCnt + 13'h0001;
          end
          else
            st_d.sub100 = st_q.sub100 + 7'd1;
        end
        if (cmdValid)
        begin
          st_d.sub100 = 7'd0;
          st_d.toCnt  = 13'h0000;
        end
        if (cmdExit || (!cmdValid && st_q.toCnt >= st_q.cmdTo))
        begin
          st_d.tout    = !cmdExit;
          st_d.cmdMode = 1'b0;
          st_d.state   = ESD_DATA;
          st_d.msCnt   = 11'h000;
        end
      end
      default: st_d.state = ESD_DATA;
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q         <= '0;
      st_q.state   <= ESD_DATA;
      st_q.escChar <= EscCharRst;
      st_q.guard   <= GuardRst;
      st_q.cmdTo   <= CmdToRst;
    end
    else
      st_q <= st_d;
  end

  assign cmdMode               = st_q.cmdMode;
  assign enterPulse            = st_q.enter;
  assign timeoutPulse          = st_q.tout;
  assign dataValid             = st_q.dValid;
  assign dataByte              = st_q.dByte;
  assign escCharSetting        = st_q.escChar;
  assign guardIntervalSetting  = st_q.guard;
  assign commandTimeoutSetting = st_q.cmdTo;

  // command mode is only entered after three escapes
  property p_enter_needs_three;
    @(posedge clk) disable iff (!rst_n)
      $rose(cmdMode) |-> $past(st_q.held) == 2'(EscCount);
  endproperty
  a_enter_needs_three: assert property (p_enter_needs_three)
    else $error("command mode entered without three escapes");

  // entry only after trailing silence of full guard
  property p_enter_after_guard;
    @(posedge clk) disable iff (!rst_n)
      enterPulse |-> $past(st_q.msCnt) >= $past(st_q.guard);
  endproperty
  a_enter_after_guard: assert property (p_enter_after_guard)
    else $error("command mode entered before trailing guard");

  // arming needs leading silence
  property p_arm_after_guard;
    @(posedge clk) disable iff (!rst_n)
      st_q.state == ESD_ARMED && $past(st_q.state) == ESD_DATA
        |-> $past(st_q.msCnt) >= $past(st_q.guard);
  endproperty
  a_arm_after_guard: assert property (p_arm_after_guard)
    else $error("armed without leading silence");

  // guard setting stays in range
  property p_guard_range;
    @(posedge clk) disable iff (!rst_n)
      guardIntervalSetting >= GuardMin && guardIntervalSetting <= GuardMax;
  endproperty
  a_guard_range: assert property (p_guard_range)
    else $error("guard setting out of range");

  // timeout setting stays in range
  property p_cmdto_range;
    @(posedge clk) disable iff (!rst_n)
      commandTimeoutSetting >= CmdToMin && commandTimeoutSetting <= CmdToMax;
  endproperty
  a_cmdto_range: assert property (p_cmdto_range)
    else $error("timeout setting out of range");

  // timeout pulse drops command mode
  property p_timeout_exit;
    @(posedge clk) disable iff (!rst_n)
      timeoutPulse |-> !cmdMode && $past(cmdMode);
  endproperty
  a_timeout_exit: assert property (p_timeout_exit)
    else $error("timeout without leaving command mode");

  // a written escape char is held next cycle
  property p_esc_write;
    @(posedge clk) disable iff (!rst_n)
      escCharWr |=> escCharSetting == $past(escCharIn);
  endproperty
  a_esc_write: assert property (p_esc_write)
    else $error("escape char write lost");

  // a mismatching byte in counting aborts to data
  property p_abort;
    @(posedge clk) disable iff (!rst_n)
      st_q.state == ESD_COUNT && rxValid && rxByte != st_q.escChar
        |=> st_q.state == ESD_DATA && dataValid && !cmdMode;
  endproperty
  a_abort: assert property (p_abort)
    else $error("mismatch did not abort sequence");

endmodule : esd_detector

// ==== src/esd_pkg.sv ====
// Purpose: shared constants for the escape sequence detector
// Assumes: 10 MHz clock
// Notes:   settings arrive as plain ports, there is no register bus
package esd_pkg;

  localparam int unsigned ClkHz       = 10_000_000;
  localparam int unsigned TickMs      = 1;
  localparam int unsigned TickCycles  = ClkHz / 1000 * TickMs;
  localparam int unsigned CmdUnitMs   = 100;
  localparam int unsigned EscCount    = 3;

  localparam logic [7:0]  EscCharRst  = 8'h2B;
  localparam logic [10:0] GuardRst    = 11'h03E8;
  localparam logic [10:0] GuardMin    = 11'h0002;
  localparam logic [10:0] GuardMax    = 11'h06D3;
  localparam logic [12:0] CmdToRst    = 13'h0064;
  localparam logic [12:0] CmdToMin    = 13'h0002;
  localparam logic [12:0] CmdToMax    = 13'h1770;

  typedef enum logic [2:0] {
    ESD_DATA, ESD_ARMED, ESD_COUNT, ESD_TRAIL, ESD_CMD
  } esd_state_e;

endpackage : esd_pkg

// ==== src/esd_tick.sv ====
// Purpose: divider giving a one-cycle enable every millisecond
// Assumes: single clock
// Notes:   period is a parameter so simulation can shorten it
`timescale 1ns/10ps
module esd_tick
  import esd_pkg::*;
#(
  parameter int unsigned Period = TickCycles
)(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // enable out
  output logic      tick
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } esd_tick_s;

  esd_tick_s st_q;
  esd_tick_s st_d;

  // count up and pulse on wrap
  always_comb
  begin
    st_d      = st_q;
    st_d.tick = 1'b0;
    if (st_q.cnt == 32'(Period - 1))
    begin
      st_d.cnt  = 32'h0000_0000;
      st_d.tick = 1'b1;
    end
    else
      st_d.cnt = st_q.cnt + 32'h0000_0001;
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign tick = st_q.tick;

endmodule : esd_tick

// ==== test/esd_host.sv ====
// Purpose: host model feeding bytes on the serial receive strobe
// Assumes: one byte per strobe, strobes never closer than every other cycle
// Notes:   idle byte lines show the inverse of the last byte, not a hold
`timescale 1ns/10ps
module esd_host (
  // clock
  input  wire logic       clk,
  // byte stream to the detector
  output logic            rxValid,
  output logic [7:0]      rxByte
);
  // idle line at time zero
  initial
  begin
    rxValid = 1'b0;
    rxByte  = 8'h00;
  end

  // one byte strobed for one cycle, then the line is released
  task automatic sendByte(input logic [7:0] b);
    @(posedge clk);
    #1;
    rxValid = 1'b1;
    rxByte  = b;
    @(posedge clk);
    #1;
    rxValid = 1'b0;
    rxByte  = ~b; // stale value must not look valid
  endtask : sendByte

  // line silence for a number of cycles
  task automatic quiet(input int n);
    repeat (n) @(posedge clk);
  endtask : quiet
endmodule : esd_host

// ==== test/escape_sequence_detector_test.sv ====
// Purpose: self-checking bench for the escape sequence detector
// Assumes: 1 ms shortened to TLen cycles, guard set to 5 ms
// Notes:   random escape chars and data bytes from a fixed seed
`timescale 1ns/10ps
module escape_sequence_detector_test;
  import esd_pkg::*;
  localparam int TLen = 10;
  logic clk = 1'b0, rst_n, rxValid, escCharWr, guardWr, cmdToWr;
  logic cmdValid, cmdExit;
  logic [7:0] rxByte, escCharIn, dataByte, escChar, ch, d;
  logic [10:0] guardIn, guardSet;
  logic [12:0] cmdToIn, cmdToSet;
  logic cmdMode, enterPulse, timeoutPulse, dataValid;
  int bad_count = 0, num_checks = 0, enterCnt = 0, toCnt = 0, dataCnt = 0;
  int seed = 1, n, d0, tc;
  logic [7:0] lastData;

  // 10 MHz clock
  always #50 clk = ~clk;

  esd_host host (.clk(clk), .rxValid(rxValid), .rxByte(rxByte));
  esd_detector #(.TickLen(TLen)) u_dut (
    .clk(clk), .rst_n(rst_n), .rxValid(rxValid), .rxByte(rxByte),
    .escCharWr(escCharWr), .escCharIn(escCharIn), .guardWr(guardWr),
    .guardIn(guardIn), .cmdToWr(cmdToWr), .cmdToIn(cmdToIn),
    .cmdValid(cmdValid), .cmdExit(cmdExit), .cmdMode(cmdMode),
    .enterPulse(enterPulse), .timeoutPulse(timeoutPulse),
    .dataValid(dataValid), .dataByte(dataByte), .escCharSetting(escChar),
    .guardIntervalSetting(guardSet), .commandTimeoutSetting(cmdToSet));

  // event counters on the result pulses
  always @(posedge clk)
  begin
    if (enterPulse === 1'b1) enterCnt <= enterCnt + 1;
    if (timeoutPulse === 1'b1) toCnt <= toCnt + 1;
    if (dataValid === 1'b1)
    begin
      dataCnt  <= dataCnt + 1;
      lastData <= dataByte;
    end
  end

  task automatic check(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask : check

  // cycles of a timeout setting, with the shortened millisecond
  function automatic int toCycles(input int units);
    return units * CmdUnitMs * TLen;
  endfunction : toCycles

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // write all three settings in one cycle
  task automatic setAll(input logic [7:0] c, input logic [10:0] g,
                        input logic [12:0] t);
    @(posedge clk);
    #1;
    escCharWr = 1'b1;
    guardWr   = 1'b1;
    cmdToWr   = 1'b1;
    escCharIn = c;
    guardIn   = g;
    cmdToIn   = t;
    @(posedge clk);
    #1;
    escCharWr = 1'b0;
    guardWr   = 1'b0;
    cmdToWr   = 1'b0;
  endtask : setAll

  // one-cycle strobe on the command feedback inputs
  task automatic pulse(input logic ex);
    @(posedge clk);
    #1;
    if (ex) cmdExit = 1'b1;
    else cmdValid = 1'b1;
    @(posedge clk);
    #1;
    cmdExit  = 1'b0;
    cmdValid = 1'b0;
  endtask : pulse

  // lead silence, three escapes, then wait on the trailing guard
  task automatic tryEnter(input logic [7:0] c, input int lead,
                          input logic ok);
    int e0, k;
    e0 = enterCnt;
    host.quiet(lead);
    repeat (3) host.sendByte(c);
    k = 0;
    while (enterCnt == e0 && k < 200)
    begin
      @(posedge clk);
      k++;
    end
    check("entered", ok, enterCnt != e0);
    if (ok) check("trailGuard", 1, k >= 4 * TLen && k <= 7 * TLen);
    if (ok) check("cmdMode", 1, cmdMode);
  endtask : tryEnter

  // watchdog
  initial
  begin
    #2_000_000;
    bad_count++;
    print_verdict();
  end

  initial
  begin
    rst_n     = 1'b0;
    escCharWr = 1'b0;
    guardWr   = 1'b0;
    cmdToWr   = 1'b0;
    cmdValid  = 1'b0;
    cmdExit   = 1'b0;
    escCharIn = 8'h00;
    guardIn   = 11'h000;
    cmdToIn   = 13'h0000;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    check("escRst", EscCharRst, escChar);
    check("guardRst", GuardRst, guardSet);
    check("cmdToRst", CmdToRst, cmdToSet);
    setAll(8'h2B, 11'h000, 13'h0000);
    check("guardLow", GuardMin, guardSet);
    check("cmdToLow", CmdToMin, cmdToSet);
    setAll(8'h2B, 11'h7FF, 13'h1FFF);
    check("guardHigh", GuardMax, guardSet);
    check("cmdToHigh", CmdToMax, cmdToSet);
    setAll(8'h2B, 11'h005, 13'h0002);
    host.sendByte(8'h41);
    tryEnter(8'h2B, 0, 1'b0);
    tryEnter(8'h2B, 7 * TLen, 1'b1);
    host.quiet(1500);
    pulse(1'b0);
    n = 0;
    d0 = toCnt;
    while (toCnt == d0 && n < 2500)
    begin
      @(posedge clk);
      n++;
    end
    tc = toCycles(CmdToMin);
    check("toWindow", 1, n >= tc - 10 && n <= tc + 10);
    check("idleAfterTo", 0, cmdMode);
    host.quiet(7 * TLen);
    d0 = dataCnt;
    repeat (2) host.sendByte(8'h2B);
    host.sendByte(8'h2A);
    host.quiet(150);
    check("abortWrong", 0, enterCnt != 1);
    check("abortCnt", d0 + 3, dataCnt);
    check("abortData", 8'h2A, lastData);
    host.quiet(7 * TLen);
    d0 = dataCnt;
    repeat (4) host.sendByte(8'h2B);
    host.quiet(150);
    check("abortFourth", 0, enterCnt != 1);
    check("fourthCnt", d0 + 4, dataCnt);
    for (int i = 0; i < 5; i++)
    begin
      ch = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
      d = 8'($random(seed));
      if (d == ch) d = ~ch;
      setAll(ch, 11'h005, 13'h0002);
      check("escSet", ch, escChar);
      d0 = dataCnt;
      host.sendByte(d);
      repeat (2) @(posedge clk);
      #1;
      check("dataCnt", d0 + 1, dataCnt);
      check("dataByte", d, lastData);
      tryEnter(ch, 7 * TLen, 1'b1);
      d0 = toCnt;
      pulse(1'b1);
      check("exit", 0, cmdMode);
      repeat (2) @(posedge clk);
      #1;
      check("exitNoTo", d0, toCnt);
    end
    // reset in mid-run brings the settings back to their defaults
    rst_n = 1'b0;
    #1;
    check("escRst2", EscCharRst, escChar);
    check("guardRst2", GuardRst, guardSet);
    check("cmdToRst2", CmdToRst, cmdToSet);
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge clk);
    print_verdict();
  end
endmodule : escape_sequence_detector_test
